// file: src/pll_config_control.sv
// Purpose: Register side of an on-chip phase-locked loop: bandwidth mode, lock status,
//          divider settings with write protection, lock-change flag and interrupt.
// Assumes: Software uses the strobe port; lock and tracking status come from the analog
//          loop asynchronously; stop, wait and break levels come from the system unit.
// Notes:   The analog loop, oscillators and glitch-free multiplexer live outside.
`default_nettype none
module pll_config_control #(
    parameter int MULT_WIDTH = 12,
    parameter int RANGE_WIDTH = 8
) (
    // Clock and reset.
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // Register strobe port.
    input  wire logic [2:0]               reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [7:0]                    reg_rdata,
    // Analog loop status, asynchronous.
    input  wire logic                     loop_locked,
    input  wire logic                     loop_tracking,
    // System state levels, bus clock domain.
    input  wire logic                     stop_mode,
    input  wire logic                     wait_mode,
    input  wire logic                     break_state,
    input  wire logic                     break_clear_enable,
    // Loop settings and interrupt.
    output pll_config_pkg::pll_cfg_s      loop_cfg,
    output logic                          loop_irq
);

    // Modulus seen by a divider: a zero setting acts as one.
    function automatic logic [11:0] modulus_of(input logic [11:0] value);
        modulus_of = (value == 12'h000) ? 12'h001 : value;
    endfunction

    logic                   auto_r;
    logic                   acq_manual_r;
    logic                   irq_enable_r;
    logic                   change_flag_r;
    logic                   power_on_r;
    logic                   base_sel_r;
    logic [1:0]             prescale_r;
    logic [1:0]             vco_power_r;
    logic [MULT_WIDTH-1:0]  feedback_r;
    logic [RANGE_WIDTH-1:0] vco_center_r;
    logic [3:0]             ref_divide_r;
    logic                   lock_meta_r;
    logic                   lock_sync_r;
    logic                   track_meta_r;
    logic                   track_sync_r;
    logic                   settled_prev_r;
    logic [7:0]             rdata_r;
    pll_config_pkg::pll_cfg_s cfg_r;
    pll_config_pkg::pll_cfg_s cfg_nxt;

    logic settled;
    logic tracking_view;
    logic wr_ctrl;
    logic wr_bw;
    logic rd_ctrl;
    logic protect;
    logic center_zero;
    logic flag_set;
    logic flag_clear;

    // Decoded strobes and write protection while the loop is powered.
    assign wr_ctrl     = reg_wr && (reg_addr == pll_config_pkg::OFF_LOOP_CONTROL);
    assign wr_bw       = reg_wr && (reg_addr == pll_config_pkg::OFF_BANDWIDTH);
    assign rd_ctrl     = reg_rd && (reg_addr == pll_config_pkg::OFF_LOOP_CONTROL);
    assign protect     = power_on_r;
    assign center_zero = (vco_center_r == '0);

    // Both status lines cross from the analog loop through two flip-flops.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_meta_r  <= 1'b0;
            lock_sync_r  <= 1'b0;
            track_meta_r <= 1'b0;
            track_sync_r <= 1'b0;
        end
        else
        begin
            lock_meta_r  <= loop_locked;
            lock_sync_r  <= lock_meta_r;
            track_meta_r <= loop_tracking;
            track_sync_r <= track_meta_r;
        end
    end

    // Settled status means nothing in manual mode, so it is forced low there.
    assign settled       = auto_r && lock_sync_r;
    assign tracking_view = auto_r ? track_sync_r : acq_manual_r;

    // Bandwidth mode and the manual tracking store.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            auto_r       <= 1'b0;
            acq_manual_r <= 1'b0;
        end
        else if (wr_bw)
        begin
            auto_r <= reg_wdata[pll_config_pkg::BIT_AUTO];
            // Writes in auto mode leave the stored manual value alone.
            if (!auto_r)
                acq_manual_r <= reg_wdata[pll_config_pkg::BIT_TRACKING];
        end
    end

    // Loop control bits; power and base select guard each other by their values before the write.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_enable_r <= 1'b0;
            power_on_r   <= pll_config_pkg::RST_POWER_ON;
            base_sel_r   <= 1'b0;
            prescale_r   <= 2'h0;
            vco_power_r  <= 2'h0;
        end
        else
        begin
            if (!auto_r)
                irq_enable_r <= 1'b0;
            else if (wr_ctrl)
                irq_enable_r <= reg_wdata[pll_config_pkg::BIT_IRQ_ENABLE];
            if (wr_ctrl && !(base_sel_r && !reg_wdata[pll_config_pkg::BIT_POWER_ON]))
                power_on_r <= reg_wdata[pll_config_pkg::BIT_POWER_ON];
            // A zero center factor forces the oscillator path whatever is written.
            if (center_zero)
                base_sel_r <= 1'b0;
            else if (wr_ctrl && (power_on_r || !reg_wdata[pll_config_pkg::BIT_BASE_SEL]))
                base_sel_r <= reg_wdata[pll_config_pkg::BIT_BASE_SEL];
            if (wr_ctrl && !protect)
            begin
                prescale_r  <= reg_wdata[pll_config_pkg::BIT_PRE_HI:pll_config_pkg::BIT_PRE_LO];
                vco_power_r <= reg_wdata[pll_config_pkg::BIT_VPR_HI:pll_config_pkg::BIT_VPR_LO];
            end
        end
    end

    // Divider settings, each frozen while the loop is powered.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            feedback_r   <= MULT_WIDTH'(pll_config_pkg::RST_FEEDBACK);
            vco_center_r <= RANGE_WIDTH'(pll_config_pkg::RST_VCO_CENTER);
            ref_divide_r <= pll_config_pkg::RST_REF_DIVIDE;
        end
        else if (reg_wr && !protect)
        begin
            case (reg_addr)
                pll_config_pkg::OFF_MULT_HIGH:
                    feedback_r[MULT_WIDTH-1:8] <= reg_wdata[pll_config_pkg::MULT_HIGH_TOP:0];
                pll_config_pkg::OFF_MULT_LOW:
                    feedback_r[7:0] <= reg_wdata;
                pll_config_pkg::OFF_VCO_RANGE:
                    vco_center_r <= reg_wdata;
                pll_config_pkg::OFF_REF_DIVIDER:
                    ref_divide_r <= reg_wdata[pll_config_pkg::REF_DIV_TOP:0];
                default:
                    feedback_r <= feedback_r;
            endcase
        end
    end

    // Change flag: set beats clear so a lock edge during a read is kept.
    assign flag_set   = auto_r && (settled != settled_prev_r);
    assign flag_clear = rd_ctrl && !(break_state && !break_clear_enable);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            settled_prev_r <= 1'b0;
            change_flag_r  <= 1'b0;
        end
        else
        begin
            settled_prev_r <= settled;
            if (!auto_r)
                change_flag_r <= 1'b0;
            else if (flag_set)
                change_flag_r <= 1'b1;
            else if (flag_clear)
                change_flag_r <= 1'b0;
        end
    end

    // Interrupt is combinational so it drops in the cycle the flag clears.
    assign loop_irq = change_flag_r && irq_enable_r && auto_r;

    // Read data is registered; unmapped offsets and reserved bits read zero.
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= pll_config_pkg::READ_ZERO;
        else if (reg_rd)
        begin
            case (reg_addr)
                pll_config_pkg::OFF_LOOP_CONTROL:
                    rdata_r <= {irq_enable_r, change_flag_r && auto_r, power_on_r, base_sel_r,
                                prescale_r, vco_power_r};
                pll_config_pkg::OFF_BANDWIDTH:
                    rdata_r <= {auto_r, settled, tracking_view, 5'h00};
                pll_config_pkg::OFF_MULT_HIGH:
                    rdata_r <= {4'h0, feedback_r[MULT_WIDTH-1:8]};
                pll_config_pkg::OFF_MULT_LOW:
                    rdata_r <= feedback_r[7:0];
                pll_config_pkg::OFF_VCO_RANGE:
                    rdata_r <= vco_center_r;
                pll_config_pkg::OFF_REF_DIVIDER:
                    rdata_r <= {4'h0, ref_divide_r};
                default:
                    rdata_r <= pll_config_pkg::READ_ZERO;
            endcase
        end
    end
    assign reg_rdata = rdata_r;

    // Settings to the loop; wait mode is deliberately not a term here.
    always_comb
    begin
        cfg_nxt                  = '0;
        cfg_nxt.feedback_modulus = modulus_of(feedback_r);
        cfg_nxt.ref_modulus      = 4'(modulus_of({8'h00, ref_divide_r}));
        cfg_nxt.vco_center       = vco_center_r;
        cfg_nxt.prescale         = prescale_r;
        cfg_nxt.vco_power        = vco_power_r;
        cfg_nxt.loop_enable      = power_on_r && !center_zero && !stop_mode;
        cfg_nxt.base_clk_sel     = base_sel_r;
        cfg_nxt.auto_mode        = auto_r;
        cfg_nxt.tracking_force   = acq_manual_r;
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cfg_r <= '0;
        else
            cfg_r <= cfg_nxt;
    end
    assign loop_cfg = cfg_r;

    // Checks of the guarded behaviour.
    chk_feedback_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        power_on_r |=> $stable(feedback_r)) else $error("Feedback factor changed while powered.");
    chk_center_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        power_on_r |=> $stable(vco_center_r)) else $error("Center factor changed while powered.");
    chk_refdiv_frozen: assert property (@(posedge clock) disable iff (!rst_b)
        power_on_r |=> $stable(ref_divide_r)) else $error("Reference divider changed while powered.");
    chk_base_needs_power: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(base_sel_r) |-> $past(power_on_r)) else $error("Base select set from an off loop.");
    chk_power_held: assert property (@(posedge clock) disable iff (!rst_b)
        base_sel_r |=> power_on_r) else $error("Loop powered off while base select set.");
    chk_zero_center: assert property (@(posedge clock) disable iff (!rst_b)
        center_zero |=> !base_sel_r ##1 !loop_cfg.loop_enable) else $error("Zero center factor left loop active.");
    chk_manual_quiet: assert property (@(posedge clock) disable iff (!rst_b)
        !auto_r |=> !loop_irq && !change_flag_r) else $error("Flag or interrupt alive in manual mode.");
    chk_flag_on_change: assert property (@(posedge clock) disable iff (!rst_b)
        auto_r && $changed(settled) |=> change_flag_r || !auto_r) else $error("Settled change did not set flag.");
    chk_break_keeps: assert property (@(posedge clock) disable iff (!rst_b)
        change_flag_r && auto_r && rd_ctrl && break_state && !break_clear_enable && !wr_bw
        |=> change_flag_r) else $error("Flag cleared during protected break.");
    chk_read_clears: assert property (@(posedge clock) disable iff (!rst_b)
        rd_ctrl && !break_state && !flag_set ##1 !flag_set |-> !change_flag_r)
        else $error("Control read did not clear flag.");
    chk_irq_follow: assert property (@(posedge clock) disable iff (!rst_b)
        loop_irq == (change_flag_r && irq_enable_r && auto_r)) else $error("Interrupt disagrees with flag and enable.");
    chk_stop_off: assert property (@(posedge clock) disable iff (!rst_b)
        stop_mode |=> !loop_cfg.loop_enable) else $error("Loop enabled during stop.");
    chk_manual_restore: assert property (@(posedge clock) disable iff (!rst_b)
        auto_r && !wr_bw |=> $stable(acq_manual_r)) else $error("Stored tracking value lost in auto mode.");

    cov_lock_irq: cover property (@(posedge clock) disable iff (!rst_b) $rose(loop_irq));
    cov_select_vco: cover property (@(posedge clock) disable iff (!rst_b) $rose(base_sel_r));
    cov_break_read: cover property (@(posedge clock) disable iff (!rst_b)
        change_flag_r && rd_ctrl && break_state && !break_clear_enable);

    // Wait mode is observed only so that it is visibly a no-op for the loop.
    logic unused_wait;
    assign unused_wait = wait_mode;

endmodule : pll_config_control
`default_nettype wire

// file: src/pll_config_pkg.sv
// Purpose: Shared constants and types for the loop configuration control block.
// Assumes: Eight-bit registers on a plain strobe port, one 50 MHz bus clock.
// Notes:   Offsets and bit positions are named here; reads pack bits by position and the bench uses literal offsets.
`default_nettype none
package pll_config_pkg;
    // Register offsets on the strobe port.
    localparam logic [2:0] OFF_LOOP_CONTROL = 3'h0;
    localparam logic [2:0] OFF_BANDWIDTH    = 3'h1;
    localparam logic [2:0] OFF_MULT_HIGH    = 3'h2;
    localparam logic [2:0] OFF_MULT_LOW     = 3'h3;
    localparam logic [2:0] OFF_VCO_RANGE    = 3'h4;
    localparam logic [2:0] OFF_REF_DIVIDER  = 3'h5;
    // Loop control register bits.
    localparam int BIT_IRQ_ENABLE = 7;
    localparam int BIT_CHANGE     = 6;
    localparam int BIT_POWER_ON   = 5;
    localparam int BIT_BASE_SEL   = 4;
    localparam int BIT_PRE_HI     = 3;
    localparam int BIT_PRE_LO     = 2;
    localparam int BIT_VPR_HI     = 1;
    localparam int BIT_VPR_LO     = 0;
    // Bandwidth control register bits and the top bits of the multiplier high and divider fields.
    localparam int BIT_AUTO      = 7;
    localparam int BIT_SETTLED   = 6;
    localparam int BIT_TRACKING  = 5;
    localparam int MULT_HIGH_TOP = 3;
    localparam int REF_DIV_TOP   = 3;
    // Reset values.
    localparam logic [11:0] RST_FEEDBACK   = 12'h040;
    localparam logic [7:0]  RST_VCO_CENTER = 8'h40;
    localparam logic [3:0]  RST_REF_DIVIDE = 4'h1;
    localparam logic        RST_POWER_ON   = 1'b1;
    localparam logic [7:0]  READ_ZERO      = 8'h00;

    // Settings handed to the analog loop and the base clock multiplexer.
    typedef struct packed {
        logic [11:0] feedback_modulus;
        logic [3:0]  ref_modulus;
        logic [7:0]  vco_center;
        logic [1:0]  prescale;
        logic [1:0]  vco_power;
        logic        loop_enable;
        logic        base_clk_sel;
        logic        auto_mode;
        logic        tracking_force;
    } pll_cfg_s;
endpackage : pll_config_pkg
`default_nettype wire

// file: testbench/pll_config_control_bench.sv
// Purpose: Self-checking bench for the loop configuration control block over its strobe port.
// Assumes: One 50 MHz clock; strobes change by non-blocking assignment at the rising edge, status and mode inputs 1 ns after it except the last lock drop.
// Notes:   Lock status is driven as a level; waits cover the two-stage synchroniser.
`default_nettype none
module pll_config_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     clock = 1'b0;
    logic                     rst_b = 1'b0;
    logic [2:0]               reg_addr = 3'h0;
    logic [7:0]               reg_wdata = 8'h00;
    logic                     reg_wr = 1'b0;
    logic                     reg_rd = 1'b0;
    logic [7:0]               reg_rdata;
    logic                     loop_locked = 1'b0;
    logic                     loop_tracking = 1'b1;
    logic                     stop_mode = 1'b0;
    logic                     wait_mode = 1'b0;
    logic                     break_state = 1'b0;
    logic                     break_clear_enable = 1'b0;
    pll_config_pkg::pll_cfg_s loop_cfg;
    logic                     loop_irq;
    int                       bad_count = 0;
    int                       comparisons = 0;

    pll_config_control uut (
        .clock              (clock),
        .rst_b              (rst_b),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_wr             (reg_wr),
        .reg_rd             (reg_rd),
        .reg_rdata          (reg_rdata),
        .loop_locked        (loop_locked),
        .loop_tracking      (loop_tracking),
        .stop_mode          (stop_mode),
        .wait_mode          (wait_mode),
        .break_state        (break_state),
        .break_clear_enable (break_clear_enable),
        .loop_cfg           (loop_cfg),
        .loop_irq           (loop_irq)
    );

    // Free-running bus clock, 20 ns period.
    always #10 clock = ~clock;

    // Compares with case inequality so an unknown never passes.
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe beside address and data.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data are taken in the cycle after it only.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", {4'h0, reg_rdata}, {4'h0, exp});
    endtask

    // Lets a lock change cross the synchroniser and reach the flag.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog sized well above the fewer than two hundred cycles that the sequence needs.
    initial
    begin
        repeat (5000) @(posedge clock);
        bad_count++;
        report_and_stop();
    end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        settle(3);
        check("feedback", loop_cfg.feedback_modulus, 12'h040);
        check("ref", {8'h00, loop_cfg.ref_modulus}, 12'h001);
        check("center", {4'h0, loop_cfg.vco_center}, 12'h040);
        rd(3'h0, 8'h20);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h3, 8'h40);
        rd(3'h4, 8'h40);
        rd(3'h5, 8'h01);
        wr(3'h6, 8'hff);
        rd(3'h6, 8'h00);
        // Divider settings are locked while the loop is powered.
        wr(3'h3, 8'h12);
        wr(3'h4, 8'h00);
        wr(3'h5, 8'h07);
        rd(3'h3, 8'h40);
        rd(3'h4, 8'h40);
        rd(3'h5, 8'h01);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h00);
        wr(3'h0, 8'h06);
        rd(3'h0, 8'h06);
        wr(3'h3, 8'h00);
        wr(3'h5, 8'h00);
        rd(3'h3, 8'h00);
        settle(3);
        check("feedback zero", loop_cfg.feedback_modulus, 12'h001);
        check("ref zero", {8'h00, loop_cfg.ref_modulus}, 12'h001);
        check("prescale", {8'h00, loop_cfg.prescale, loop_cfg.vco_power}, 12'h006);
        wr(3'h3, 8'h40);
        wr(3'h5, 8'h01);
        // A zero centre factor disables the loop and blocks the base select.
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h20);
        wr(3'h0, 8'h30);
        rd(3'h0, 8'h20);
        settle(3);
        check("enable zero", {11'h0, loop_cfg.loop_enable}, 12'h000);
        wr(3'h0, 8'h00);
        wr(3'h4, 8'h40);
        rd(3'h4, 8'h40);
        // Select needs the loop on first, and then blocks powering off.
        wr(3'h0, 8'h30);
        rd(3'h0, 8'h20);
        wr(3'h0, 8'h30);
        rd(3'h0, 8'h30);
        settle(3);
        check("base sel", {11'h0, loop_cfg.base_clk_sel}, 12'h001);
        wr(3'h0, 8'h00);
        rd(3'h0, 8'h20);
        wr(3'h0, 8'h20);
        // Tracking bit: control in manual, status in auto.
        wr(3'h1, 8'h20);
        rd(3'h1, 8'h20);
        settle(3);
        check("track force", {11'h0, loop_cfg.tracking_force}, 12'h001);
        wr(3'h1, 8'ha0);
        rd(3'h1, 8'ha0);
        loop_tracking <= 1'b0;
        settle(4);
        check("auto mode", {11'h0, loop_cfg.auto_mode}, 12'h001);
        wr(3'h1, 8'ha0);
        rd(3'h1, 8'h80);
        // Lock change sets the flag with the interrupt masked.
        loop_locked <= 1'b1;
        settle(6);
        check("irq masked", {11'h0, loop_irq}, 12'h000);
        rd(3'h1, 8'hc0);
        rd(3'h0, 8'h60);
        rd(3'h0, 8'h20);
        wr(3'h0, 8'ha0);
        rd(3'h0, 8'ha0);
        loop_locked <= 1'b0;
        settle(6);
        check("irq on", {11'h0, loop_irq}, 12'h001);
        // Break without clear enable keeps the flag through reads.
        break_state <= 1'b1;
        rd(3'h0, 8'he0);
        rd(3'h0, 8'he0);
        break_clear_enable <= 1'b1;
        rd(3'h0, 8'he0);
        check("irq drop", {11'h0, loop_irq}, 12'h000);
        rd(3'h0, 8'ha0);
        break_state <= 1'b0;
        break_clear_enable <= 1'b0;
        // Wait leaves the loop running and able to interrupt.
        wait_mode <= 1'b1;
        loop_locked <= 1'b1;
        settle(6);
        check("wait irq", {11'h0, loop_irq}, 12'h001);
        check("wait enable", {11'h0, loop_cfg.loop_enable}, 12'h001);
        rd(3'h0, 8'he0);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        settle(3);
        check("stop enable", {11'h0, loop_cfg.loop_enable}, 12'h000);
        stop_mode <= 1'b0;
        // After stop the loop is confirmed settled before the base select is set again.
        rd(3'h1, 8'hc0);
        wr(3'h0, 8'hb0);
        rd(3'h0, 8'hb0);
        wr(3'h0, 8'ha0);
        // Back to manual: stored tracking value returns, flag and enable read zero.
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h20);
        rd(3'h0, 8'h20);
        wr(3'h0, 8'ha0);
        loop_locked <= 1'b0;
        settle(6);
        check("manual irq", {11'h0, loop_irq}, 12'h000);
        rd(3'h0, 8'h20);
        // Manual start-up: tracking is cleared before the loop is powered.
        wr(3'h0, 8'h00);
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h20);
        rd(3'h1, 8'h00);
        rd(3'h0, 8'h20);
        report_and_stop();
    end
endmodule // pll_config_control_bench
`default_nettype wire
